//--- rtl/fp_classify_pkg.sv
package fp_classify_pkg;

	// single precision layout
	localparam int SP_WIDTH     = 32;
	localparam int SP_EXP_W     = 8;
	localparam int SP_FRAC_W    = 23;
	localparam logic [7:0] SP_EXP_MAX = 8'hff;
	localparam int SP_BIAS      = 127;

	// double precision layout
	localparam int DP_WIDTH     = 64;
	localparam int DP_EXP_W     = 11;
	localparam int DP_FRAC_W    = 52;
	localparam logic [10:0] DP_EXP_MAX = 11'h7ff;
	localparam int DP_BIAS      = 1023;

	// status register field positions
	localparam int FSR_RD_LSB   = 30;
	localparam int FSR_TEM_LSB  = 23;
	localparam int FSR_FTT_LSB  = 14;
	localparam int FSR_QNE_BIT  = 13;
	localparam int FSR_ACCRUED_EXCEPTION_FIELD_LSB = 5;
	localparam int FSR_CURRENT_EXCEPTION_FIELD_LSB = 0;
	localparam logic [31:0] FSR_RESET = 32'h0000_0000;

	// ieee condition bit positions inside current_exception_field and accrued_exception_field
	localparam int EXC_NX = 0;
	localparam int EXC_DZ = 1;
	localparam int EXC_UF = 2;
	localparam int EXC_OF = 3;
	localparam int EXC_NV = 4;

	typedef enum logic [2:0] {
		CLS_ZERO     = 3'b000,
		CLS_DENORMAL = 3'b001,
		CLS_NORMAL   = 3'b010,
		CLS_INF      = 3'b011,
		CLS_QNAN     = 3'b100,
		CLS_SNAN     = 3'b101
	} class_t;

	typedef enum logic [3:0] {
		OP_ADD     = 4'h0,
		OP_SUB     = 4'h1,
		OP_MUL     = 4'h2,
		OP_DIV     = 4'h3,
		OP_SQRT    = 4'h4,
		OP_CMP     = 4'h5,
		OP_CVT_INT = 4'h6,
		OP_CVT_FP  = 4'h7,
		OP_MOVE    = 4'h8,
		OP_LOAD    = 4'h9,
		OP_STORE   = 4'ha,
		OP_STQ     = 4'hb,
		OP_UNSUP   = 4'hc
	} op_t;

	typedef enum logic [1:0] {
		RND_NEAREST = 2'b00,
		RND_ZERO    = 2'b01,
		RND_POS     = 2'b10,
		RND_NEG     = 2'b11
	} rnd_t;

	typedef enum logic [2:0] {
		FTT_NONE     = 3'b000,
		FTT_IEEE     = 3'b001,
		FTT_UNFIN    = 3'b010,
		FTT_UNIMP    = 3'b011,
		FTT_SEQUENCE = 3'b100
	} ftt_t;

	typedef enum logic [1:0] {
		MODE_EXEC    = 2'b00,
		MODE_PENDING = 2'b01,
		MODE_EXCEPT  = 2'b10
	} mode_t;

endpackage

//--- rtl/fp_format_classify_exceptions.sv
// Contract
// - single value is sign, 8-bit biased exponent, 23-bit fraction in 32 bits.
// - single exp 0 gives zero or denormal; exp 255 gives infinity or NaN.
// - normal single has hidden leading one and exponent bias 127.
// - NaN with fraction msb set is quiet, otherwise signaling.
// - double value is sign, 11-bit exponent, 52-bit fraction in 64 bits.
// - double exp 2047 marks infinity or NaN; bias 1023 with hidden one.
// - extended-precision instructions never execute; unimplemented trap instead.
// - denormal operand or denormal result raises unfinished instead of computing; the code exempts moves.
// - any NaN operand of an operate instruction raises unfinished; the code exempts moves.
// - float-to-integer overflow raises unfinished.
// - unsupported operate instructions raise unimplemented, extended ones included.
// - non-store in pending or exception mode is sequence error; only stores run.
// - five ieee conditions in current and accrued fields; inexact pairs only.
// - invalid for signaling NaN, inf-inf, 0*inf, 0/0, inf/inf, sqrt negative, cvt, compare NaN.
// - untrapped invalid with floating destination delivers a quiet NaN.
// - zero divisor with finite nonzero dividend is division by zero; signed infinity.
// - overflow when unbounded rounded result exceeds largest finite value.
// - untrapped overflow result chosen by rounding direction and sign.
// - underflow never signaled by hardware; unfinished trap covers it.
// - inexact when any extra bit beyond the fraction is one before rounding.
// - exception raises request, enters pending mode, suspends operate instructions.
// - request holds until acknowledge, then released unless a non-store instruction arrives in the same cycle.
`timescale 1ns/1ns
`default_nettype none

module fp_format_classify_exceptions
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        instr_valid,
	input  wire logic [3:0]  instr_op,
	input  wire logic        instr_double,
	input  wire logic        instr_extended,
	input  wire logic [63:0] operand_a,
	input  wire logic [63:0] operand_b,
	input  wire logic [63:0] arith_result,
	input  wire logic        arith_sign,
	input  wire logic        arith_overflow,
	input  wire logic        arith_denormal,
	input  wire logic [2:0]  arith_extra_bits,
	input  wire logic        cvt_overflow,
	input  wire logic        queue_empty,
	input  wire logic        fp_exception_acknowledge,
	input  wire logic        fsr_write,
	input  wire logic [31:0] fsr_wdata,
	output logic [63:0]      result_data,
	output logic             result_valid,
	output logic [2:0]       operand_a_class,
	output logic [2:0]       operand_b_class,
	output logic             fp_exception_request,
	output logic             sequence_error,
	output logic [1:0]       fp_mode,
	output logic [31:0]      fp_status_register
);

	function automatic fp_classify_pkg::class_t classify(input logic [63:0] v, input logic dbl);
		logic [10:0] e;
		logic [51:0] f;
		logic        top;
		logic        emax;
		e    = '0;
		f    = '0;
		top  = 1'b0;
		emax = 1'b0;
		if (dbl)
		begin
			e    = v[62:52];
			f    = v[51:0];
			top  = v[51];
			emax = (e == fp_classify_pkg::DP_EXP_MAX);
		end
		else
		begin
			e    = {3'h0, v[30:23]};
			f    = {29'h0, v[22:0]};
			top  = v[22];
			emax = (v[30:23] == fp_classify_pkg::SP_EXP_MAX);
		end
		if (e == 11'h000)
			classify = (f == '0) ? fp_classify_pkg::CLS_ZERO : fp_classify_pkg::CLS_DENORMAL;
		else if (emax)
		begin
			if (f == '0)
				classify = fp_classify_pkg::CLS_INF;
			else
				classify = top ? fp_classify_pkg::CLS_QNAN : fp_classify_pkg::CLS_SNAN;
		end
		else
			classify = fp_classify_pkg::CLS_NORMAL; // hidden one, bias per format
	endfunction

	function automatic logic [63:0] make_inf(input logic s, input logic dbl);
		if (dbl)
			make_inf = {s, fp_classify_pkg::DP_EXP_MAX, 52'h0};
		else
			make_inf = {32'h0, s, fp_classify_pkg::SP_EXP_MAX, 23'h0};
	endfunction

	function automatic logic [63:0] make_max(input logic s, input logic dbl);
		if (dbl)
			make_max = {s, 11'h7fe, {52{1'b1}}};
		else
			make_max = {32'h0, s, 8'hfe, {23{1'b1}}};
	endfunction

	function automatic logic is_nan(input fp_classify_pkg::class_t c);
		is_nan = (c == fp_classify_pkg::CLS_QNAN) || (c == fp_classify_pkg::CLS_SNAN);
	endfunction

	fp_classify_pkg::class_t cls_a;
	fp_classify_pkg::class_t cls_b;
	fp_classify_pkg::op_t    op;
	fp_classify_pkg::rnd_t   rnd;
	fp_classify_pkg::mode_t  mode_q;
	fp_classify_pkg::mode_t  mode_d;
	logic [1:0]  rd_q,   rd_d;
	logic [4:0]  tem_q,  tem_d;
	logic [2:0]  ftt_q,  ftt_d;
	logic [4:0]  accrued_exception_field_q, accrued_exception_field_d;
	logic [4:0]  current_exception_field_q, current_exception_field_d;
	logic        req_q,  req_d;
	logic        seq_q,  seq_d;
	logic [63:0] res_q,  res_d;
	logic        rv_q,   rv_d;
	logic [2:0]  ca_q,   ca_d;
	logic [2:0]  cb_q,   cb_d;
	logic        two_ops;
	logic        operate;
	logic        is_store;
	logic        unimp;
	logic        unfin;
	logic        nv;
	logic        dz;
	logic        of;
	logic        nx;
	logic [4:0]  exc;
	logic        trap_ieee;
	logic [63:0] dflt;
	logic        sign_a;
	logic        sign_b;
	logic        eff_sub;
	assign op       = fp_classify_pkg::op_t'(instr_op);
	assign rnd      = fp_classify_pkg::rnd_t'(rd_q);
	assign cls_a    = classify(operand_a, instr_double);
	assign cls_b    = classify(operand_b, instr_double);
	assign sign_a   = instr_double ? operand_a[63] : operand_a[31];
	assign sign_b   = instr_double ? operand_b[63] : operand_b[31];
	assign is_store = (op == fp_classify_pkg::OP_STORE) || (op == fp_classify_pkg::OP_STQ);
	assign operate  = !is_store && (op != fp_classify_pkg::OP_LOAD);
	assign two_ops  = (op == fp_classify_pkg::OP_ADD) || (op == fp_classify_pkg::OP_SUB)
		|| (op == fp_classify_pkg::OP_MUL) || (op == fp_classify_pkg::OP_DIV)
		|| (op == fp_classify_pkg::OP_CMP);
	assign eff_sub  = (sign_a ^ sign_b) ^ (op == fp_classify_pkg::OP_SUB);
	// exception detection for one operate instruction
	always_comb
	begin
		unimp = operate && (instr_extended || (op == fp_classify_pkg::OP_UNSUP));
		unfin = 1'b0;
		if (operate && (op != fp_classify_pkg::OP_MOVE))
		begin
			if (cls_a == fp_classify_pkg::CLS_DENORMAL || (two_ops && cls_b == fp_classify_pkg::CLS_DENORMAL))
				unfin = 1'b1;
			if (arith_denormal)
				unfin = 1'b1; // also covers underflow
			if (is_nan(cls_a) || (two_ops && is_nan(cls_b)))
				unfin = 1'b1;
			if (op == fp_classify_pkg::OP_CVT_INT && cvt_overflow)
				unfin = 1'b1;
		end
		nv = 1'b0;
		if (cls_a == fp_classify_pkg::CLS_SNAN || (two_ops && cls_b == fp_classify_pkg::CLS_SNAN))
			nv = (op != fp_classify_pkg::OP_MOVE); // moves never raise invalid
		case (op)
			fp_classify_pkg::OP_ADD, fp_classify_pkg::OP_SUB:
				nv = nv | (cls_a == fp_classify_pkg::CLS_INF && cls_b == fp_classify_pkg::CLS_INF && eff_sub);
			fp_classify_pkg::OP_MUL:
				nv = nv | (cls_a == fp_classify_pkg::CLS_ZERO && cls_b == fp_classify_pkg::CLS_INF)
					| (cls_a == fp_classify_pkg::CLS_INF && cls_b == fp_classify_pkg::CLS_ZERO);
			fp_classify_pkg::OP_DIV:
				nv = nv | (cls_a == fp_classify_pkg::CLS_ZERO && cls_b == fp_classify_pkg::CLS_ZERO)
					| (cls_a == fp_classify_pkg::CLS_INF && cls_b == fp_classify_pkg::CLS_INF);
			fp_classify_pkg::OP_SQRT:
				nv = nv | (sign_a && cls_a != fp_classify_pkg::CLS_ZERO && !is_nan(cls_a));
			fp_classify_pkg::OP_CVT_INT:
				nv = nv | cvt_overflow | (cls_a == fp_classify_pkg::CLS_INF) | is_nan(cls_a);
			fp_classify_pkg::OP_CMP:
				nv = nv | is_nan(cls_a) | is_nan(cls_b);
			default:
				nv = nv;
		endcase
		dz = (op == fp_classify_pkg::OP_DIV) && !nv && (cls_b == fp_classify_pkg::CLS_ZERO)
			&& (cls_a == fp_classify_pkg::CLS_NORMAL || cls_a == fp_classify_pkg::CLS_DENORMAL);
		// only overflow and inexact may pair with each other
		of = !nv && !dz && arith_overflow && (op != fp_classify_pkg::OP_CMP);
		nx = !nv && !dz && (of || (arith_extra_bits != 3'h0));
		exc = 5'h00;
		exc[fp_classify_pkg::EXC_NV] = nv;
		exc[fp_classify_pkg::EXC_DZ] = dz;
		exc[fp_classify_pkg::EXC_OF] = of;
		exc[fp_classify_pkg::EXC_NX] = nx; // underflow bit left clear
		trap_ieee = (exc & tem_q) != 5'h00;
	end

	// default results for untrapped conditions
	always_comb
	begin
		dflt = arith_result;
		if (nv && op != fp_classify_pkg::OP_CVT_INT && op != fp_classify_pkg::OP_CMP)
			dflt = instr_double ? {1'b0, fp_classify_pkg::DP_EXP_MAX, 1'b1, 51'h0}
				: {32'h0, 1'b0, fp_classify_pkg::SP_EXP_MAX, 1'b1, 22'h0};
		else if (dz)
			dflt = make_inf(sign_a ^ sign_b, instr_double);
		else if (of)
		begin
			case (rnd)
				fp_classify_pkg::RND_NEAREST: dflt = make_inf(arith_sign, instr_double);
				fp_classify_pkg::RND_ZERO:    dflt = make_max(arith_sign, instr_double);
				fp_classify_pkg::RND_NEG:     dflt = arith_sign ? make_inf(1'b1, instr_double)
					: make_max(1'b0, instr_double);
				fp_classify_pkg::RND_POS:     dflt = arith_sign ? make_max(1'b1, instr_double)
					: make_inf(1'b0, instr_double);
				default:                      dflt = arith_result;
			endcase
		end
	end

	// mode, request and status register
	always_comb
	begin
		mode_d = mode_q;
		rd_d   = rd_q;
		tem_d  = tem_q;
		ftt_d  = ftt_q;
		accrued_exception_field_d = accrued_exception_field_q;
		current_exception_field_d = current_exception_field_q;
		req_d  = req_q;
		seq_d  = 1'b0;
		res_d  = res_q;
		rv_d   = 1'b0;
		ca_d   = ca_q;
		cb_d   = cb_q;
		if (fsr_write)
		begin
			rd_d   = fsr_wdata[fp_classify_pkg::FSR_RD_LSB +: 2];
			tem_d  = fsr_wdata[fp_classify_pkg::FSR_TEM_LSB +: 5];
			accrued_exception_field_d = fsr_wdata[fp_classify_pkg::FSR_ACCRUED_EXCEPTION_FIELD_LSB +: 5];
			current_exception_field_d = fsr_wdata[fp_classify_pkg::FSR_CURRENT_EXCEPTION_FIELD_LSB +: 5];
		end
		case (mode_q)
			fp_classify_pkg::MODE_EXEC:
			begin
				if (instr_valid && operate)
				begin
					ca_d = cls_a;
					cb_d = cls_b;
					if (unimp || unfin || trap_ieee)
					begin
						mode_d = fp_classify_pkg::MODE_PENDING;
						req_d  = 1'b1;
						if (unimp)
							ftt_d = fp_classify_pkg::FTT_UNIMP;
						else if (unfin)
							ftt_d = fp_classify_pkg::FTT_UNFIN;
						else
						begin
							ftt_d  = fp_classify_pkg::FTT_IEEE;
							current_exception_field_d = exc;
						end
					end
					else
					begin
						ftt_d  = fp_classify_pkg::FTT_NONE;
						current_exception_field_d = exc;
						accrued_exception_field_d = accrued_exception_field_d | exc;
						res_d  = dflt;
						rv_d   = 1'b1;
					end
				end
			end
			fp_classify_pkg::MODE_PENDING:
			begin
				if (fp_exception_acknowledge)
				begin
					mode_d = fp_classify_pkg::MODE_EXCEPT;
					req_d  = 1'b0;
				end
				if (instr_valid && !is_store)
				begin
					mode_d = fp_classify_pkg::MODE_PENDING;
					req_d  = 1'b1;
					seq_d  = 1'b1;
					ftt_d  = fp_classify_pkg::FTT_SEQUENCE;
				end
			end
			fp_classify_pkg::MODE_EXCEPT:
			begin
				if (instr_valid && !is_store)
				begin
					mode_d = fp_classify_pkg::MODE_PENDING;
					req_d  = 1'b1;
					seq_d  = 1'b1;
					ftt_d  = fp_classify_pkg::FTT_SEQUENCE;
				end
				else if (queue_empty)
					mode_d = fp_classify_pkg::MODE_EXEC;
			end
			default:
				mode_d = fp_classify_pkg::MODE_EXEC;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q <= fp_classify_pkg::MODE_EXEC;
			rd_q   <= fp_classify_pkg::FSR_RESET[fp_classify_pkg::FSR_RD_LSB +: 2];
			tem_q  <= fp_classify_pkg::FSR_RESET[fp_classify_pkg::FSR_TEM_LSB +: 5];
			ftt_q  <= fp_classify_pkg::FSR_RESET[fp_classify_pkg::FSR_FTT_LSB +: 3];
			accrued_exception_field_q <= fp_classify_pkg::FSR_RESET[fp_classify_pkg::FSR_ACCRUED_EXCEPTION_FIELD_LSB +: 5];
			current_exception_field_q <= fp_classify_pkg::FSR_RESET[fp_classify_pkg::FSR_CURRENT_EXCEPTION_FIELD_LSB +: 5];
			req_q  <= 1'b0;
			seq_q  <= 1'b0;
			res_q  <= 64'h0;
			rv_q   <= 1'b0;
			ca_q   <= 3'h0;
			cb_q   <= 3'h0;
		end
		else
		begin
			mode_q <= mode_d;
			rd_q   <= rd_d;
			tem_q  <= tem_d;
			ftt_q  <= ftt_d;
			accrued_exception_field_q <= accrued_exception_field_d;
			current_exception_field_q <= current_exception_field_d;
			req_q  <= req_d;
			seq_q  <= seq_d;
			res_q  <= res_d;
			rv_q   <= rv_d;
			ca_q   <= ca_d;
			cb_q   <= cb_d;
		end
	end

	assign result_data          = res_q;
	assign result_valid         = rv_q;
	assign operand_a_class      = ca_q;
	assign operand_b_class      = cb_q;
	assign fp_exception_request = req_q;
	assign sequence_error       = seq_q;
	assign fp_mode              = mode_q;

	always_comb
	begin
		fp_status_register = 32'h0000_0000;
		fp_status_register[fp_classify_pkg::FSR_RD_LSB +: 2]   = rd_q;
		fp_status_register[fp_classify_pkg::FSR_TEM_LSB +: 5]  = tem_q;
		fp_status_register[fp_classify_pkg::FSR_FTT_LSB +: 3]  = ftt_q;
		fp_status_register[fp_classify_pkg::FSR_QNE_BIT]       = !queue_empty;
		fp_status_register[fp_classify_pkg::FSR_ACCRUED_EXCEPTION_FIELD_LSB +: 5] = accrued_exception_field_q;
		fp_status_register[fp_classify_pkg::FSR_CURRENT_EXCEPTION_FIELD_LSB +: 5] = current_exception_field_q;
	end

endmodule

`default_nettype wire

//--- tb/fp_classify_sva.sv
`timescale 1ns/1ns
`default_nettype none

module fp_classify_chk
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        instr_valid,
	input wire logic [3:0]  instr_op,
	input wire logic        instr_double,
	input wire logic        instr_extended,
	input wire logic [63:0] operand_a,
	input wire logic        fsr_write,
	input wire logic        fp_exception_acknowledge,
	input wire logic        result_valid,
	input wire logic        fp_exception_request,
	input wire logic        sequence_error,
	input wire logic [1:0]  fp_mode,
	input wire logic [31:0] fp_status_register
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic       exec;
	logic       arith;
	logic       store;
	logic [2:0] ftt;
	assign exec  = instr_valid && fp_mode == fp_classify_pkg::MODE_EXEC;
	assign arith = instr_op <= fp_classify_pkg::OP_CVT_INT;
	assign store = instr_op == fp_classify_pkg::OP_STORE || instr_op == fp_classify_pkg::OP_STQ;
	assign ftt   = fp_status_register[16:14];

	req_hold_a: assert property (fp_exception_request && !fp_exception_acknowledge |=> fp_exception_request)
		else $error("request dropped before acknowledge");
	req_release_a: assert property (fp_exception_request && fp_exception_acknowledge && !instr_valid
		|=> !fp_exception_request && fp_mode == fp_classify_pkg::MODE_EXCEPT)
		else $error("request not released on acknowledge");
	pend_enter_a: assert property ($rose(fp_exception_request) |-> fp_mode == fp_classify_pkg::MODE_PENDING)
		else $error("request without pending mode");
	unimp_trap_a: assert property (exec && instr_extended && arith
		|=> fp_exception_request && ftt == fp_classify_pkg::FTT_UNIMP)
		else $error("extended operation not refused");
	denorm_trap_a: assert property (exec && !instr_extended && arith && !instr_double
		&& operand_a[30:23] == 8'h00 && operand_a[22:0] != 23'h0
		|=> fp_exception_request && ftt == fp_classify_pkg::FTT_UNFIN)
		else $error("denormal operand not unfinished");
	nan_trap_a: assert property (exec && !instr_extended && arith && instr_double
		&& operand_a[62:52] == 11'h7ff && operand_a[51:0] != 52'h0
		|=> fp_exception_request && ftt == fp_classify_pkg::FTT_UNFIN)
		else $error("nan operand not unfinished");
	seq_error_a: assert property (instr_valid && fp_mode != fp_classify_pkg::MODE_EXEC && !store
		|=> sequence_error)
		else $error("missing sequence error");
	store_quiet_a: assert property (instr_valid && fp_mode != fp_classify_pkg::MODE_EXEC && store
		|=> !sequence_error)
		else $error("store gave sequence error");
	ops_halted_a: assert property (instr_valid && fp_mode != fp_classify_pkg::MODE_EXEC |=> !result_valid)
		else $error("result delivered while halted");
	uf_never_a: assert property ($rose(fp_status_register[2]) || $rose(fp_status_register[7])
		|-> $past(fsr_write))
		else $error("underflow raised by hardware");
	exc_combo_a: assert property (result_valid |-> $onehot0(fp_status_register[4:1]))
		else $error("illegal condition combination");
endmodule

bind fp_format_classify_exceptions fp_classify_chk i_chk (.core_clk, .rst_n, .instr_valid, .instr_op,
	.instr_double, .instr_extended, .operand_a, .fsr_write, .fp_exception_acknowledge, .result_valid,
	.fp_exception_request, .sequence_error, .fp_mode, .fp_status_register);

`default_nettype wire

//--- tb/iu_model.sv
`timescale 1ns/1ns
`default_nettype none

module iu_model
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       fp_exception_request,
	input  wire logic [3:0] ack_delay,
	output var  logic       fp_exception_acknowledge
);
	logic [3:0] wait_q;
	// trap taken a programmable number of cycles after the request
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_q <= 4'h0;
			fp_exception_acknowledge <= 1'b0;
		end
		else if (fp_exception_request && !fp_exception_acknowledge)
		begin
			wait_q <= wait_q + 4'h1;
			fp_exception_acknowledge <= wait_q == ack_delay;
		end
		else
		begin
			wait_q <= 4'h0;
			fp_exception_acknowledge <= 1'b0;
		end
	end
endmodule

`default_nettype wire

//--- tb/fp_format_classify_exceptions_test.sv
`timescale 1ns/1ns
`default_nettype none

module fp_format_classify_exceptions_test;
	typedef struct packed {
		logic [63:0] data;
		logic [2:0]  cls;
		logic [4:0]  current_exception_field;
		logic [4:0]  accrued_exception_field;
	} note_t;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        instr_valid = 1'b0;
	logic [3:0]  instr_op = 4'h0;
	logic        instr_double = 1'b0;
	logic        instr_extended = 1'b0;
	logic [63:0] operand_a = 64'h0;
	logic [63:0] operand_b = 64'h0;
	logic [63:0] arith_result = 64'h0;
	logic        arith_sign = 1'b0;
	logic        arith_overflow = 1'b0;
	logic        arith_denormal = 1'b0;
	logic [2:0]  arith_extra_bits = 3'h0;
	logic        cvt_overflow = 1'b0;
	logic        queue_empty = 1'b0;
	logic        fsr_write = 1'b0;
	logic [31:0] fsr_wdata = 32'h0;
	logic        fp_exception_acknowledge;
	logic [63:0] result_data;
	logic        result_valid;
	logic [2:0]  operand_a_class;
	logic [2:0]  operand_b_class;
	logic        fp_exception_request;
	logic        sequence_error;
	logic [1:0]  fp_mode;
	logic [31:0] fp_status_register;
	int          err_count = 0;
	int          comparisons = 0;
	int          i;
	int          r;
	note_t       exp_q[$];
	note_t       nt;
	logic [31:0] seed = 32'h10804ac3;
	logic [4:0]  accrued_exception_field_m = 5'h00;
	logic [63:0] v;
	logic [63:0] w;
	logic        s;
	logic [63:0] vals [0:13] = '{64'h0, 64'h8000_0001, 64'h3f80_0000, 64'h7f7f_ffff, 64'hff80_0000,
		64'h7fc0_0000, 64'h7f80_0001, 64'h8000_0000_0000_0000, 64'h000f_ffff_ffff_ffff,
		64'h3ff0_0000_0000_0000, 64'h7fef_ffff_ffff_ffff, 64'h7ff0_0000_0000_0000,
		64'h7ff8_0000_0000_0001, 64'h7ff4_0000_0000_0000};
	logic [3:0]  nv_op [0:4] = '{fp_classify_pkg::OP_MUL, fp_classify_pkg::OP_ADD, fp_classify_pkg::OP_DIV,
		fp_classify_pkg::OP_SQRT, fp_classify_pkg::OP_SUB};
	logic [63:0] nv_a [0:4] = '{64'h0, 64'h7ff0_0000_0000_0000, 64'h0, 64'hbff0_0000_0000_0000,
		64'h7ff0_0000_0000_0000};
	logic [63:0] nv_b [0:4] = '{64'h7ff0_0000_0000_0000, 64'hfff0_0000_0000_0000, 64'h0, 64'h0,
		64'h7ff0_0000_0000_0000};

	fp_format_classify_exceptions i_dut (.core_clk, .rst_n, .instr_valid, .instr_op, .instr_double,
		.instr_extended, .operand_a, .operand_b, .arith_result, .arith_sign, .arith_overflow, .arith_denormal,
		.arith_extra_bits, .cvt_overflow, .queue_empty, .fp_exception_acknowledge, .fsr_write, .fsr_wdata,
		.result_data, .result_valid, .operand_a_class, .operand_b_class, .fp_exception_request,
		.sequence_error, .fp_mode, .fp_status_register);
	iu_model i_iu (.core_clk, .rst_n, .fp_exception_request, .ack_delay(4'ha), .fp_exception_acknowledge);

	always #10 core_clk = ~core_clk;

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [2:0] cls_of(input logic dbl, input logic [63:0] x);
		logic [10:0] e;
		logic [51:0] f;
		e = dbl ? x[62:52] : {3'h0, x[30:23]};
		f = dbl ? x[51:0] : {x[22:0], 29'h0};
		if (e == 11'h0)
			return (f == 52'h0) ? fp_classify_pkg::CLS_ZERO : fp_classify_pkg::CLS_DENORMAL;
		if (e != (dbl ? 11'h7ff : 11'h0ff))
			return fp_classify_pkg::CLS_NORMAL;
		if (f == 52'h0)
			return fp_classify_pkg::CLS_INF;
		return f[51] ? fp_classify_pkg::CLS_QNAN : fp_classify_pkg::CLS_SNAN;
	endfunction

	task wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task check(input logic [63:0] seen, input logic [63:0] want);
		comparisons++;
		if (seen !== want)
		begin
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
			err_count++;
		end
	endtask

	task op_go(input logic [3:0] op, input logic dbl, input logic [63:0] a, input logic [63:0] b,
		input logic [63:0] res, input logic [2:0] xb, input logic [4:0] fl);
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_double <= dbl;
		operand_a <= a;
		operand_b <= b;
		arith_result <= res;
		arith_extra_bits <= xb;
		{instr_extended, arith_denormal, arith_overflow, arith_sign, cvt_overflow} <= fl;
		@(posedge core_clk);
		instr_valid <= 1'b0;
	endtask

	task note(input logic [63:0] d, input logic [2:0] c, input logic [4:0] x);
		accrued_exception_field_m = accrued_exception_field_m | x;
		exp_q.push_back({d, c, x, accrued_exception_field_m});
	endtask

	task fsr_set(input logic [31:0] d);
		@(posedge core_clk);
		fsr_write <= 1'b1;
		fsr_wdata <= d;
		@(posedge core_clk);
		fsr_write <= 1'b0;
		accrued_exception_field_m = 5'h00;
	endtask

	task wait_mode(input logic [1:0] m);
		int n;
		for (n = 0; n < 60 && fp_mode !== m; n++)
			@(negedge core_clk);
		check(fp_mode, m);
		if (fp_mode !== m)
			wrap_up();
	endtask

	// pending: load refused, store quiet; then ack, drain, back to exec
	task trap(input logic [2:0] ftt);
		wait_mode(fp_classify_pkg::MODE_PENDING);
		check(fp_exception_request, 1'b1);
		check(fp_status_register[16:14], ftt);
		op_go(fp_classify_pkg::OP_LOAD, 1'b0, 64'h0, 64'h0, 64'h0, 3'h0, 5'h00);
		@(negedge core_clk);
		check(sequence_error, 1'b1);
		op_go(fp_classify_pkg::OP_STORE, 1'b0, 64'h0, 64'h0, 64'h0, 3'h0, 5'h00);
		@(negedge core_clk);
		check(sequence_error, 1'b0);
		wait_mode(fp_classify_pkg::MODE_EXCEPT);
		check(fp_exception_request, 1'b0);
		@(posedge core_clk);
		queue_empty <= 1'b1;
		wait_mode(fp_classify_pkg::MODE_EXEC);
		@(posedge core_clk);
		queue_empty <= 1'b0;
	endtask

	always @(negedge core_clk)
		if (result_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(64'h1, 64'h0);
			else
			begin
				nt = exp_q.pop_front();
				check(result_data, nt.data);
				check(operand_a_class, nt.cls);
				check(fp_status_register[9:0], {nt.accrued_exception_field, nt.current_exception_field});
			end
		end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		$display("[FAIL] %0t run limit reached", $time);
		wrap_up();
	end

	initial
	begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		check(fp_status_register, 32'h0000_2000);
		fsr_set(32'h0);
		for (i = 0; i < 14; i++)
		begin
			v = (i < 7) ? {rnd(), vals[i][31:0]} : vals[i];
			w = (i < 7) ? {32'h0, v[31:0]} : v;
			note(w, cls_of(i >= 7, v), 5'h00);
			op_go(fp_classify_pkg::OP_MOVE, i >= 7, v, 64'h0, w, 3'h0, 5'h00);
		end
		for (i = 0; i < 8; i++)
		begin
			v = {rnd(), rnd()};
			w = {rnd(), rnd()};
			v[62:61] = 2'b01;
			note(w, fp_classify_pkg::CLS_NORMAL, {4'h0, v[2:0] != 3'h0});
			op_go(fp_classify_pkg::OP_ADD, 1'b1, v, v, w, v[2:0], 5'h00);
		end
		for (r = 0; r < 8; r++)
		begin
			s = r[0];
			fsr_set({r[2:1], 30'h0});
			v = ((r >> 1) == 0 || (r >> 1) == 2 && !s || (r >> 1) == 3 && s)
				? {s, 11'h7ff, 52'h0} : {s, 11'h7fe, {52{1'b1}}};
			note(v, fp_classify_pkg::CLS_NORMAL, 5'h09);
			op_go(fp_classify_pkg::OP_MUL, 1'b1, 64'h7fe0_0000_0000_0000, 64'h7fe0_0000_0000_0000, 64'h0,
				3'h5, {3'b001, s, 1'b0});
		end
		fsr_set(32'h0);
		for (r = 0; r < 2; r++)
		begin
			s = r[0];
			note({~s, 11'h7ff, 52'h0}, fp_classify_pkg::CLS_NORMAL, 5'h02);
			op_go(fp_classify_pkg::OP_DIV, 1'b1, 64'hc000_0000_0000_0000, {s, 63'h0}, 64'h0, 3'h0,
				{3'b000, ~s, 1'b0});
		end
		for (i = 0; i < 5; i++)
		begin
			note(64'h7ff8_0000_0000_0000, cls_of(1'b1, nv_a[i]), 5'h10);
			op_go(nv_op[i], 1'b1, nv_a[i], nv_b[i], 64'h0, 3'h0, 5'h00);
		end
		note(64'h5, fp_classify_pkg::CLS_NORMAL, 5'h00);
		op_go(fp_classify_pkg::OP_CMP, 1'b1, vals[9], vals[10], 64'h5, 3'h0, 5'h00);
		op_go(fp_classify_pkg::OP_ADD, 1'b1, vals[9], vals[9], 64'h0, 3'h0, 5'h10);
		trap(fp_classify_pkg::FTT_UNIMP);
		op_go(fp_classify_pkg::OP_UNSUP, 1'b1, vals[9], vals[9], 64'h0, 3'h0, 5'h00);
		trap(fp_classify_pkg::FTT_UNIMP);
		op_go(fp_classify_pkg::OP_ADD, 1'b0, vals[1], vals[2], 64'h0, 3'h0, 5'h00);
		trap(fp_classify_pkg::FTT_UNFIN);
		op_go(fp_classify_pkg::OP_ADD, 1'b1, vals[9], vals[9], 64'h0, 3'h0, 5'h08);
		trap(fp_classify_pkg::FTT_UNFIN);
		op_go(fp_classify_pkg::OP_MUL, 1'b1, vals[12], vals[9], 64'h0, 3'h0, 5'h00);
		trap(fp_classify_pkg::FTT_UNFIN);
		op_go(fp_classify_pkg::OP_CVT_INT, 1'b1, vals[10], 64'h0, 64'h0, 3'h0, 5'h01);
		trap(fp_classify_pkg::FTT_UNFIN);
		fsr_set(32'h0800_0000);
		op_go(fp_classify_pkg::OP_MUL, 1'b1, 64'h0, vals[11], 64'h0, 3'h0, 5'h00);
		trap(fp_classify_pkg::FTT_IEEE);
		check(fp_status_register[9:0], 10'h010);
		check(operand_b_class, fp_classify_pkg::CLS_INF);
		repeat (2) @(negedge core_clk);
		check(exp_q.size(), 64'h0);
		wrap_up();
	end
endmodule

`default_nettype wire
